// [design/acs_regs.vh]
// register map, field layout and timing constants of the converter control
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
// register addresses
`define ACS_ADDR_W 4
`define ACS_ADR_SEL 4'h0
`define ACS_ADR_CTRL 4'h1
`define ACS_ADR_STAT 4'h2
// input select fields
`define ACS_SEL_MASK 16'h9F9F
`define ACS_SEL_RESET 16'h0000
`define ACS_POS_A_LO 0
`define ACS_POS_A_HI 4
`define ACS_NEG_A_BIT 7
`define ACS_POS_B_LO 8
`define ACS_POS_B_HI 12
`define ACS_NEG_B_BIT 15
`define ACS_POS_MAX2 5'h0F
// control fields
`define ACS_CTL_PWR 0
`define ACS_CTL_AUTO 1
`define ACS_CTL_TRIG 2
`define ACS_CTL_SAMP 3
`define ACS_CTL_ALT 4
// converter clock divider: one converter period is 20 core cycles
`define ACS_TAD_DIV 5'h13
`define ACS_TAD_HALF 5'h09
// timing in converter periods
`define ACS_PRE_TAD 3'h2
`define ACS_SAMP_TAD 3'h2
`define ACS_CONV_TAD 4'hC
`define ACS_TRIG_TAD 2'h2
// power-up settle: 20 us at 4 ns
`define ACS_POWER_UP_SETTLE_TIME_US 20
`define ACS_CLK_NS 4
`define ACS_POWER_UP_SETTLE_TIME_CYC ((`ACS_POWER_UP_SETTLE_TIME_US * 1000) / `ACS_CLK_NS)
`endif

// [design/acs_tad_gen.v]
// converter clock period tick generator
`include "acs_regs.vh"
module acs_tad_gen (
    input wire clk_i,
    input wire rst_b_i,
    input wire run_i,
    output reg tick_o,
    output reg half_o
);
    reg [4:0] cnt_q;
    always @(posedge clk_i) begin
        if (!rst_b_i || !run_i) begin
            cnt_q <= 5'h00;
            tick_o <= 1'b0;
            half_o <= 1'b0;
        end else begin
            tick_o <= (cnt_q == `ACS_TAD_DIV);
            half_o <= (cnt_q == `ACS_TAD_HALF);
            if (cnt_q == `ACS_TAD_DIV) begin
                cnt_q <= 5'h00;
            end else begin
                cnt_q <= cnt_q + 5'h01;
            end
        end
    end
endmodule

// [design/acs_top.v]
// converter input select and sample/convert sequencing
//
// Design decisions made here: strobed register access and the address map.
`include "acs_regs.vh"
module acs_top #(
    parameter SECOND_CONV = 0,
    parameter POWER_UP_SETTLE_TIME_CYC = `ACS_POWER_UP_SETTLE_TIME_CYC
) (
    input wire MCLK_I,
    input wire RST_B_I,
    input wire [3:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire TRIG_I,
    output reg [15:0] RDATA_O,
    output reg [4:0] POS_SEL_O,
    output reg NEG_SEL_O,
    output reg SAMPLING_O,
    output reg CONVERTING_O,
    output reg DONE_O,
    output reg VALID_O
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    localparam ST_IDLE = 3'd0;
    localparam ST_PRE = 3'd1;
    localparam ST_SAMP = 3'd2;
    localparam ST_CONV = 3'd3;
    localparam ST_GAP = 3'd4;

    reg [15:0] sel_q;
    reg [4:0] ctl_q;
    reg [2:0] st_q;
    reg [3:0] cnt_q;
    reg side_b_q;
    reg [12:0] pu_q;
    reg pu_ok_q;
    reg trig_pend_q;
    reg [1:0] trg_cnt_q;
    reg gap_half_q;
    wire trig_ready = trig_pend_q && (trg_cnt_q == `ACS_TRIG_TAD);
    wire tick;
    wire half;
    wire wr_sel = WR_I && (ADDR_I == `ACS_ADR_SEL);
    wire wr_ctl = WR_I && (ADDR_I == `ACS_ADR_CTRL);
    wire pwr = ctl_q[`ACS_CTL_PWR];

    function [4:0] clip_pos;
        input [4:0] v;
        begin
            if (SECOND_CONV != 0 && v > `ACS_POS_MAX2) begin
                clip_pos = `ACS_POS_MAX2;
            end else begin
                clip_pos = v;
            end
        end
    endfunction

    acs_tad_gen u_tad (
        .clk_i(MCLK_I),
        .rst_b_i(RST_B_I),
        .run_i(pwr),
        .tick_o(tick),
        .half_o(half)
    );

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            sel_q <= `ACS_SEL_RESET;
            ctl_q <= 5'h00;
        end else begin
            if (wr_sel) begin
                sel_q <= WDATA_I & `ACS_SEL_MASK;
            end
            if (wr_ctl) begin
                ctl_q <= WDATA_I[4:0];
            end else if (st_q == ST_PRE && ctl_q[`ACS_CTL_SAMP]) begin
                ctl_q[`ACS_CTL_SAMP] <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            RDATA_O <= 16'h0000;
        end else if (RD_I) begin
            case (ADDR_I)
                `ACS_ADR_SEL: RDATA_O <= sel_q & `ACS_SEL_MASK;
                `ACS_ADR_CTRL: RDATA_O <= {11'h000, ctl_q};
                `ACS_ADR_STAT: RDATA_O <= {10'h000, pu_ok_q, side_b_q,
                    1'b0, st_q};
                default: RDATA_O <= 16'h0000;
            endcase
        end else begin
            RDATA_O <= 16'h0000;
        end
    end

    // ------------------------------------------------------------
    // power-up settle
    // ------------------------------------------------------------
    always @(posedge MCLK_I) begin
        if (!RST_B_I || !pwr) begin
            pu_q <= 13'h0000;
            pu_ok_q <= 1'b0;
        end else if (pu_q == POWER_UP_SETTLE_TIME_CYC[12:0] - 13'h0001) begin
            pu_ok_q <= 1'b1;
        end else begin
            pu_q <= pu_q + 13'h0001;
        end
    end

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always @(posedge MCLK_I) begin
        if (!RST_B_I || !pwr) begin
            st_q <= ST_IDLE;
            cnt_q <= 4'h0;
            side_b_q <= 1'b0;
            trig_pend_q <= 1'b0;
            trg_cnt_q <= 2'h0;
            gap_half_q <= 1'b0;
            DONE_O <= 1'b0;
        end else begin
            DONE_O <= 1'b0;
            // count converter periods from the trigger itself
            if (TRIG_I && !ctl_q[`ACS_CTL_TRIG] && !trig_pend_q) begin
                trig_pend_q <= 1'b1;
                trg_cnt_q <= {1'b0, tick};
            end else if (trig_pend_q && tick && !trig_ready) begin
                trg_cnt_q <= trg_cnt_q + 2'h1;
            end
            case (st_q)
                ST_IDLE: begin
                    cnt_q <= 4'h0;
                    if (ctl_q[`ACS_CTL_SAMP] || ctl_q[`ACS_CTL_AUTO]) begin
                        st_q <= ST_PRE;
                        // a tick at this edge already counts
                        cnt_q <= {3'h0, tick};
                    end
                end
                ST_PRE: begin
                    if (tick) begin
                        if (cnt_q[2:0] == `ACS_PRE_TAD) begin
                            st_q <= ST_SAMP;
                            cnt_q <= 4'h0;
                            trig_pend_q <= 1'b0;
                            trg_cnt_q <= 2'h0;
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_SAMP: begin
                    if (tick && gap_half_q) begin
                        // a half-period start is no full period
                        gap_half_q <= 1'b0;
                    end else if (tick) begin
                        if (cnt_q < 4'hF) begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                        // window already holds two periods
                        if (cnt_q[2:0] >= `ACS_SAMP_TAD - 3'h1 &&
                            (ctl_q[`ACS_CTL_TRIG] || trig_ready)) begin
                            st_q <= ST_CONV;
                            cnt_q <= 4'h0;
                            trig_pend_q <= 1'b0;
                            trg_cnt_q <= 2'h0;
                        end
                    end
                end
                ST_CONV: begin
                    if (tick) begin
                        if (cnt_q == `ACS_CONV_TAD - 4'h1) begin
                            st_q <= ST_GAP;
                            DONE_O <= 1'b1;
                            cnt_q <= 4'h0;
                            gap_half_q <= 1'b0;
                            if (ctl_q[`ACS_CTL_ALT]) begin
                                side_b_q <= ~side_b_q;
                            end
                        end else begin
                            cnt_q <= cnt_q + 4'h1;
                        end
                    end
                end
                ST_GAP: begin
                    if (!ctl_q[`ACS_CTL_AUTO]) begin
                        st_q <= ST_IDLE;
                    end else if (half) begin
                        st_q <= ST_SAMP;
                        cnt_q <= 4'h0;
                        gap_half_q <= 1'b1;
                    end
                end
                default: st_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            POS_SEL_O <= 5'h00;
            NEG_SEL_O <= 1'b0;
            SAMPLING_O <= 1'b0;
            CONVERTING_O <= 1'b0;
            VALID_O <= 1'b0;
        end else begin
            if (side_b_q) begin
                POS_SEL_O <= clip_pos(
                    sel_q[`ACS_POS_B_HI:`ACS_POS_B_LO]);
                NEG_SEL_O <= sel_q[`ACS_NEG_B_BIT];
            end else begin
                POS_SEL_O <= clip_pos(
                    sel_q[`ACS_POS_A_HI:`ACS_POS_A_LO]);
                NEG_SEL_O <= sel_q[`ACS_NEG_A_BIT];
            end
            SAMPLING_O <= pwr && (st_q == ST_SAMP);
            CONVERTING_O <= pwr && (st_q == ST_CONV);
            VALID_O <= pwr && pu_ok_q;
        end
    end
endmodule

// [testbench/acs_checker.sv]
// assertions on the converter control top ports
module acs_checker #(
    parameter SECOND_CONV = 0,
    parameter POWER_UP_SETTLE_TIME_CYC = 50
) (
    input wire MCLK_I,
    input wire RST_B_I,
    input wire [3:0] ADDR_I,
    input wire [15:0] WDATA_I,
    input wire WR_I,
    input wire RD_I,
    input wire TRIG_I,
    input wire [15:0] RDATA_O,
    input wire [4:0] POS_SEL_O,
    input wire NEG_SEL_O,
    input wire SAMPLING_O,
    input wire CONVERTING_O,
    input wire DONE_O,
    input wire VALID_O
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [2:0] ctl_q;
    reg [15:0] sc_q;
    reg [15:0] pc_q;
    default clocking cb @(posedge MCLK_I); endclocking
    default disable iff (!RST_B_I);
    // shadow of power, auto sample, auto trigger; window and power counters
    always @(posedge MCLK_I) begin
        if (!RST_B_I) begin
            ctl_q <= 3'h0;
            sc_q <= 16'h0000;
            pc_q <= 16'h0000;
        end else begin
            if (WR_I && ADDR_I == 4'h1)
                ctl_q <= WDATA_I[2:0];
            sc_q <= SAMPLING_O ? sc_q + 16'h0001 : 16'h0000;
            pc_q <= ctl_q[0] ? pc_q + {15'h0000, ~&pc_q} : 16'h0000;
        end
    end
    AST_SEL_ZERO: assert property (
        RD_I && ADDR_I == 4'h0 |=> (RDATA_O & 16'h6060) == 16'h0000)
        else $error("unused select bits read nonzero");
    AST_POS_LIMIT: assert property (
        SECOND_CONV != 0 |-> POS_SEL_O <= 5'h0F)
        else $error("positive select above 15");
    AST_SAMP_START: assert property (
        WR_I && ADDR_I == 4'h1 && WDATA_I[3] && ctl_q[0] && !SAMPLING_O
        && !CONVERTING_O |-> ##[38:62] $rose(SAMPLING_O))
        else $error("sampling start late or early");
    AST_CONV_START: assert property (
        $rose(TRIG_I) && SAMPLING_O && !ctl_q[2]
        |-> ##[38:62] $rose(CONVERTING_O))
        else $error("conversion start out of range");
    AST_WINDOW: assert property (
        $fell(SAMPLING_O) && CONVERTING_O |-> sc_q >= 16'h0026)
        else $error("sample window too short");
    AST_CONV_LEN: assert property (
        $rose(CONVERTING_O) |-> ##[235:245] DONE_O)
        else $error("conversion length wrong");
    AST_AUTO_GAP: assert property (
        DONE_O && ctl_q[1:0] == 2'h3 |-> ##[1:24] $rose(SAMPLING_O))
        else $error("auto sample restart late");
    AST_SETTLE_MIN: assert property (
        VALID_O |-> pc_q >= POWER_UP_SETTLE_TIME_CYC - 2)
        else $error("valid too early");
    AST_SETTLE_MAX: assert property (
        pc_q >= POWER_UP_SETTLE_TIME_CYC + 3 |-> VALID_O)
        else $error("valid too late");
    cover property ($rose(CONVERTING_O));
    cover property (DONE_O && ctl_q[1]);
    cover property ($rose(VALID_O));
endmodule
bind acs_top acs_checker #(.SECOND_CONV(SECOND_CONV), .POWER_UP_SETTLE_TIME_CYC(POWER_UP_SETTLE_TIME_CYC))
    chk (.MCLK_I(MCLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .TRIG_I(TRIG_I),
    .RDATA_O(RDATA_O), .POS_SEL_O(POS_SEL_O), .NEG_SEL_O(NEG_SEL_O),
    .SAMPLING_O(SAMPLING_O), .CONVERTING_O(CONVERTING_O),
    .DONE_O(DONE_O), .VALID_O(VALID_O));

// [testbench/acs_pins.sv]
// analog input pins: the selected pair shows as pin index and negative pick
module acs_pins (
    input wire logic [4:0] pos_i,
    input wire logic neg_i,
    output logic [5:0] level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    assign level_o = {pos_i, neg_i};
endmodule

// [testbench/acs_top_test.sv]
// self-checking bench for the converter control top
module acs_top_test;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rst_b = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic trig = 1'b0;
    logic [15:0] rdata;
    logic [4:0] pos_sel;
    logic neg_sel, sampling, converting, done, valid;
    logic [5:0] level;
    wire [3:0] flags = {converting, done, sampling, valid};
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    acs_top #(.SECOND_CONV(1), .POWER_UP_SETTLE_TIME_CYC(50)) DUT (.MCLK_I(mclk),
        .RST_B_I(rst_b), .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr),
        .RD_I(rd), .TRIG_I(trig), .RDATA_O(rdata), .POS_SEL_O(pos_sel),
        .NEG_SEL_O(neg_sel), .SAMPLING_O(sampling),
        .CONVERTING_O(converting), .DONE_O(done), .VALID_O(valid));
    acs_pins pins (.pos_i(pos_sel), .neg_i(neg_sel), .level_o(level));
    initial begin
        forever #2 mclk = ~mclk;
    end
    task close_out;
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            mismatches++;
            close_out();
        end
    end
    task chk(input string what, input logic [15:0] exp, got);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected %s exp %h got %h", what, exp, got);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task rd_reg(input logic [3:0] a, input logic [15:0] exp);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1 chk("read data", exp, rdata);
    endtask
    // bounded wait on converting, done, sampling or valid, off the edge
    task wait_hi(input int k);
        int n;
        for (n = 0; flags[k] !== 1'b1 && n < 2000; n++)
            @(negedge mclk);
        chk("flag wait", 16'h0001, {15'h0000, flags[k]});
    endtask
    task pulse_trig;
        @(posedge mclk);
        trig <= 1'b1;
        @(posedge mclk);
        trig <= 1'b0;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        rd_reg(4'h0, 16'h0000);
        wr_reg(4'h0, 16'hFFFF);
        rd_reg(4'h0, 16'h9F9F);
        rd_reg(4'h7, 16'h0000);
        $display("test registers done");
        wr_reg(4'h0, 16'h8A15);
        wr_reg(4'h1, 16'h0001);
        wait_hi(0);
        rd_reg(4'h2, 16'h0020);
        $display("test power done");
        wr_reg(4'h1, 16'h0019);
        wait_hi(1);
        chk("pins side a", 16'h001E, {10'h000, level});
        rd_reg(4'h1, 16'h0011);
        pulse_trig();
        wait_hi(3);
        wait_hi(2);
        wr_reg(4'h1, 16'h0019);
        wait_hi(1);
        chk("pins side b", 16'h0015, {10'h000, level});
        pulse_trig();
        wait_hi(2);
        $display("test manual sides done");
        wr_reg(4'h1, 16'h001B);
        wait_hi(1);
        pulse_trig();
        wait_hi(2);
        @(negedge mclk);
        wait_hi(1);
        wr_reg(4'h1, 16'h0007);
        wait_hi(3);
        wait_hi(2);
        $display("test auto sample done");
        close_out();
    end
endmodule
